// *** src/fhc_host_regs_regs.vh ***
// Purpose: constants for the floppy host control register bank
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   all registers are 8 bits wide in byte lane 0
`ifndef FHC_HOST_REGS_REGS_VH
`define FHC_HOST_REGS_REGS_VH

// register indices
`define FHC_IDX_DRIVE_OUT     4'h2
`define FHC_IDX_TAPE          4'h3
`define FHC_IDX_MAIN_STATUS   4'h4
`define FHC_IDX_RATE          4'h4
`define FHC_IDX_CONFIG_CTRL   4'h7
`define FHC_IDX_MODE          4'h8
`define FHC_IDX_MEDIA_BOOT    4'h9
`define FHC_IDX_DRIVE_TYPE    4'ha

// drive output control fields
`define FHC_DO_MOTOR_A        4
`define FHC_DO_DMA_INT_EN     3
`define FHC_DO_CORE_RUN       2
`define FHC_DO_SEL_LSB        0
`define FHC_DO_RESET          8'h00

// rate select fields
`define FHC_RS_SW_RESET       7
`define FHC_RS_POWER_DOWN     6
`define FHC_RS_SHIFT_LSB      2
`define FHC_RS_CODE_LSB       0
`define FHC_RS_RESET          8'h02

// main status fields
`define FHC_MS_READY          7
`define FHC_MS_DIR            6
`define FHC_MS_NON_DMA        5
`define FHC_MS_BUSY           4

// mode register fields
`define FHC_MODE_THREE        0
`define FHC_MODE_COMPAT       1

// tape assign layout in three-mode
`define FHC_MB_MEDIA_LSB      4
`define FHC_MB_BOOT_LSB       6

// other reset values
`define FHC_TAPE_RESET        2'h0
`define FHC_CC_RESET          2'h2
`define FHC_MODE_RESET        2'h0
`define FHC_MEDIA_RESET       8'h00
`define FHC_DTYPE_RESET       8'hff

// timing
`define FHC_CLK_NS            4
`define FHC_SWRST_NS          100
// 100 ns rounded up to whole 4 ns clocks, sized for the 8-bit counter
`define FHC_SWRST_CYCLES      8'd25

// bus responses
`define FHC_RESP_OKAY         2'h0
`define FHC_RESP_SLVERR       2'h2

`endif

// *** src/fhc_sync2.v ***
// Purpose: two-flop synchroniser for levels from outside the clock domain
// Assumes: input changes slowly compared with clk
// Notes:   stage one is read only by stage two
`timescale 1ns/10ps
module fhc_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // level in and out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // plain double register, nothing taps meta
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // fhc_sync2

// *** src/fhc_host_regs.v ***
// Purpose: host control and status registers of a floppy disk controller
// Assumes: AXI4-Lite slave, one write and one read under way at a time
// Notes:   core status inputs are on clk; the master reset pin is not
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "fhc_host_regs_regs.vh"
module fhc_host_regs #(
  parameter [7:0] SWRST_CYCLES = `FHC_SWRST_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // axi4-lite write address
  input  wire [5:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [5:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pin
  input  wire        master_reset_input,
  // controller core status
  input  wire        core_data_ready,
  input  wire        core_to_host,
  input  wire        core_exec_phase,
  input  wire        core_non_dma,
  input  wire        core_cmd_busy,
  input  wire [3:0]  core_seeking,
  input  wire        core_dma_req,
  input  wire        core_irq,
  // drive and core control
  output reg         motor_a_en,
  output reg  [1:0]  drive_sel,
  output wire        dma_req_out,
  output wire        irq_out,
  output reg         core_reset,
  output reg         power_down,
  output reg  [2:0]  write_shift_sel,
  output reg  [1:0]  data_rate,
  output reg         reduced_write_current,
  output reg  [1:0]  tape_select,
  output reg  [3:0]  tape_drive_en
);

  // register decode, shared by read and write sides
  function fhc_mapped;
    input [3:0] idx;
    input       is_wr;
    begin
      case (idx)
        `FHC_IDX_DRIVE_OUT:   fhc_mapped = 1'b1;
        `FHC_IDX_TAPE:        fhc_mapped = 1'b1;
        `FHC_IDX_RATE:        fhc_mapped = 1'b1;
        `FHC_IDX_CONFIG_CTRL: fhc_mapped = is_wr;
        `FHC_IDX_MODE:        fhc_mapped = 1'b1;
        `FHC_IDX_MEDIA_BOOT:  fhc_mapped = 1'b1;
        `FHC_IDX_DRIVE_TYPE:  fhc_mapped = 1'b1;
        default:              fhc_mapped = 1'b0;
      endcase
    end
  endfunction

  // speed codes 00 and 11 need reduced write current
  function fhc_rwc;
    input [1:0] code;
    begin
      fhc_rwc = (code == 2'h0) || (code == 2'h3);
    end
  endfunction

  // register state
  reg  [7:0] drive_out;
  reg  [1:0] tape_sel;
  reg  [1:0] rate_code;
  reg  [2:0] shift_sel;
  reg        pdown;
  reg        swrst_busy;
  reg  [7:0] swrst_cnt;
  reg  [1:0] cc_rate;
  reg        last_was_cc;
  reg  [1:0] mode;
  reg  [7:0] media_boot_config;
  reg  [7:0] drive_type_config;

  // bus capture state
  reg  [5:0] aw_addr_q;
  reg        have_aw;
  reg  [7:0] w_byte_q;
  reg        w_lane_q;
  reg        have_w;

  wire       mr_sync;
  wire       wr_fire;
  wire [3:0] wr_idx;
  wire       wr_ok;
  wire       wr_en;
  wire [3:0] rd_idx;
  wire       rd_fire;
  wire       three_mode_enable;
  wire       compat_mode;
  wire [1:0] drive_type_sel;
  wire [7:0] tape_read;
  wire [7:0] main_status;
  reg  [7:0] rd_byte;

  // the pin crosses in before anything looks at it
  fhc_sync2 #(
    .W (1)
  ) u_mr_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (master_reset_input),
    .q       (mr_sync)
  );

  // address and data are taken independently, response after both
  assign s_axi_awready = ~have_aw & ~s_axi_bvalid;
  assign s_axi_wready  = ~have_w & ~s_axi_bvalid;
  assign wr_fire       = have_aw & have_w & ~s_axi_bvalid;
  assign wr_idx        = aw_addr_q[5:2];
  assign wr_ok         = fhc_mapped(wr_idx, 1'b1);
  assign wr_en         = wr_fire & wr_ok & w_lane_q;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_addr_q    <= 6'h00;
      have_aw      <= 1'b0;
      w_byte_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      have_w       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FHC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q <= s_axi_awaddr;
        have_aw   <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
        have_w   <= 1'b1;
      end
      if (wr_fire)
      begin
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `FHC_RESP_OKAY : `FHC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // drive output control: master reset wins over any write
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drive_out <= `FHC_DO_RESET;
    end
    else if (mr_sync)
    begin
      drive_out <= `FHC_DO_RESET;
    end
    else if (wr_en && wr_idx == `FHC_IDX_DRIVE_OUT)
    begin
      drive_out <= {3'h0, w_byte_q[4:0]};
    end
  end

  // tape select and configuration registers
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tape_sel          <= `FHC_TAPE_RESET;
      mode              <= `FHC_MODE_RESET;
      media_boot_config <= `FHC_MEDIA_RESET;
      drive_type_config <= `FHC_DTYPE_RESET;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `FHC_IDX_TAPE:       tape_sel          <= w_byte_q[1:0];
        `FHC_IDX_MODE:       mode              <= w_byte_q[1:0];
        `FHC_IDX_MEDIA_BOOT: media_boot_config <= w_byte_q;
        `FHC_IDX_DRIVE_TYPE: drive_type_config <= w_byte_q;
        default:             tape_sel          <= tape_sel;
      endcase
    end
  end

  // only the speed code field of the rate default is nonzero
  localparam [7:0] RS_DEFAULT = `FHC_RS_RESET;

  // rate select; master reset reloads the default speed code
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rate_code <= RS_DEFAULT[1:0];
      shift_sel <= 3'h0;
      pdown     <= 1'b0;
    end
    else if (mr_sync)
    begin
      rate_code <= RS_DEFAULT[1:0];
      shift_sel <= 3'h0;
      pdown     <= 1'b0;
    end
    else if (wr_en && wr_idx == `FHC_IDX_RATE)
    begin
      rate_code <= w_byte_q[`FHC_RS_CODE_LSB +: 2];
      shift_sel <= w_byte_q[`FHC_RS_SHIFT_LSB +: 3];
      pdown     <= w_byte_q[`FHC_RS_POWER_DOWN];
    end
  end

  // config control speed and which source wrote last
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cc_rate     <= `FHC_CC_RESET;
      last_was_cc <= 1'b0;
    end
    else if (wr_en && wr_idx == `FHC_IDX_CONFIG_CTRL)
    begin
      cc_rate     <= w_byte_q[1:0];
      last_was_cc <= 1'b1;
    end
    else if (wr_en && wr_idx == `FHC_IDX_RATE)
    begin
      last_was_cc <= 1'b0;
    end
  end

  // software reset: fixed-length pulse, a new request restarts it
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      swrst_busy <= 1'b0;
      swrst_cnt  <= 8'h00;
    end
    else if (wr_en && wr_idx == `FHC_IDX_RATE && w_byte_q[`FHC_RS_SW_RESET])
    begin
      swrst_busy <= 1'b1;
      swrst_cnt  <= SWRST_CYCLES - 8'h01;
    end
    else if (swrst_busy)
    begin
      if (swrst_cnt == 8'h00)
      begin
        swrst_busy <= 1'b0;
      end
      else
      begin
        swrst_cnt <= swrst_cnt - 8'h01;
      end
    end
  end

  // drive-facing outputs, all from flops
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      motor_a_en            <= 1'b0;
      drive_sel             <= 2'h0;
      core_reset            <= 1'b1;
      power_down            <= 1'b0;
      write_shift_sel       <= 3'h0;
      data_rate             <= `FHC_CC_RESET;
      reduced_write_current <= 1'b0;
      tape_select           <= 2'h0;
      tape_drive_en         <= 4'h0;
    end
    else
    begin
      motor_a_en      <= drive_out[`FHC_DO_MOTOR_A];
      drive_sel       <= drive_out[`FHC_DO_SEL_LSB +: 2];
      core_reset      <= ~drive_out[`FHC_DO_CORE_RUN] | swrst_busy;
      power_down      <= pdown;
      write_shift_sel <= shift_sel;
      tape_select     <= tape_sel;
      // compat modes only honour the config control write
      if (compat_mode || last_was_cc)
      begin
        data_rate             <= cc_rate;
        reduced_write_current <= fhc_rwc(cc_rate);
      end
      else
      begin
        data_rate             <= rate_code;
        reduced_write_current <= fhc_rwc(rate_code);
      end
      // drive 0 stays the boot drive and is never a tape
      case (tape_sel)
        2'h1:    tape_drive_en <= 4'h2;
        2'h2:    tape_drive_en <= 4'h4;
        2'h3:    tape_drive_en <= 4'h8;
        default: tape_drive_en <= 4'h0;
      endcase
    end
  end

  // request gating is a handshake path, kept combinational
  assign dma_req_out = core_dma_req & drive_out[`FHC_DO_DMA_INT_EN];
  assign irq_out     = core_irq & drive_out[`FHC_DO_DMA_INT_EN];

  // tape register read view depends on the layout mode
  assign three_mode_enable = mode[`FHC_MODE_THREE];
  assign compat_mode       = mode[`FHC_MODE_COMPAT];
  assign drive_type_sel    = drive_type_config[{drive_out[1:0], 1'b0} +: 2];
  assign tape_read = three_mode_enable ?
                     {media_boot_config[`FHC_MB_MEDIA_LSB +: 2],
                      drive_type_sel,
                      media_boot_config[`FHC_MB_BOOT_LSB +: 2],
                      tape_sel} :
                     {6'h00, tape_sel};

  // main status is live core state, sampled at the read
  assign main_status = {core_data_ready,
                        core_to_host,
                        core_exec_phase & core_non_dma,
                        core_cmd_busy,
                        core_seeking};

  // read mux; write-only registers read as zero
  assign rd_idx = s_axi_araddr[5:2];
  always @*
  begin
    case (rd_idx)
      `FHC_IDX_TAPE:        rd_byte = tape_read;
      `FHC_IDX_MAIN_STATUS: rd_byte = main_status;
      `FHC_IDX_MODE:        rd_byte = {6'h00, mode};
      `FHC_IDX_MEDIA_BOOT:  rd_byte = media_boot_config;
      `FHC_IDX_DRIVE_TYPE:  rd_byte = drive_type_config;
      default:              rd_byte = 8'h00;
    endcase
  end

  // read channel: one outstanding read, data held until taken
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `FHC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      if (fhc_mapped(rd_idx, 1'b0))
      begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= `FHC_RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `FHC_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // fhc_host_regs

// *** verification/fhc_host_regs_asserts.sv ***
// Purpose: bus and output checks on the host register bank
// Assumes: sees only the ports of fhc_host_regs
// Notes:   latencies follow the bank's handshakes: one cycle to read data, two to a write response
`timescale 1ns/10ps
module fhc_host_regs_asserts #(
  parameter [7:0] SWRST_CYCLES = 8'd25
) (
  // clock and reset
  input logic        clk,
  input logic        sys_rst,
  // bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // pin, core and drive side
  input logic        master_reset_input,
  input logic        core_dma_req,
  input logic        core_irq,
  input logic        dma_req_out,
  input logic        irq_out,
  input logic        motor_a_en,
  input logic [1:0]  drive_sel,
  input logic        core_reset,
  input logic [1:0]  data_rate,
  input logic        reduced_write_current,
  input logic [3:0]  tape_drive_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // the enable bit may only block a request, never invent one
  chk_req_gate:
    assert property ((~{core_dma_req, core_irq} & {dma_req_out, irq_out}) == 2'h0)
    else $error("request out without core request");
  // drive 0 stays the boot drive, so never a tape enable
  chk_tape_onehot: assert property (!tape_drive_en[0] && $onehot0(tape_drive_en))
    else $error("bad tape drive enable");
  chk_rwc_code:
    assert property (reduced_write_current == (data_rate == 2'h0 || data_rate == 2'h3))
    else $error("write current does not match rate code");
  // pin is synchronised, so allow its two stages plus the drive_out and output stages
  chk_mr_clear:
    assert property (master_reset_input [*6] |-> !motor_a_en && drive_sel == 2'h0 && core_reset)
    else $error("output control not cleared by master reset");
  chk_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");

  cov_mr: cover property (master_reset_input [*6]);
  cov_swrst: cover property ($fell(core_reset));
  cov_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // fhc_host_regs_asserts

bind fhc_host_regs fhc_host_regs_asserts #(
  .SWRST_CYCLES(SWRST_CYCLES)
) u_chk (.*);

// *** verification/fhc_core_model.sv ***
// Purpose: behavioural disk controller core feeding status levels
// Assumes: stim set by the bench, same clock as the bank
// Notes:   levels drop while the core is held in reset
`timescale 1ns/10ps
module fhc_core_model (
  // clock and reset
  input  logic        clk,
  input  logic        sys_rst,
  // control in
  input  logic        core_reset,
  input  logic [10:0] stim,
  // status out
  output logic        core_irq,
  output logic        core_dma_req,
  output logic        core_data_ready,
  output logic        core_to_host,
  output logic        core_exec_phase,
  output logic        core_non_dma,
  output logic        core_cmd_busy,
  output logic [3:0]  core_seeking
);
  logic [10:0] st;

  // a core in reset claims neither the data register nor a drive
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= 11'h000;
    else if (core_reset)
      st <= 11'h000;
    else
      st <= stim;
  end

  // ready and direction follow the bench's pattern one clock late, through the st register
  assign {core_irq, core_dma_req, core_data_ready, core_to_host, core_exec_phase,
    core_non_dma, core_cmd_busy, core_seeking} = st;
endmodule // fhc_core_model

// *** verification/fhc_host_regs_test.sv ***
// Purpose: register-level test of the floppy host control bank
// Assumes: one write and one read under way at a time
// Notes:   software reset shortened to two cycles
`timescale 1ns/10ps
`include "fhc_host_regs_regs.vh"
module fhc_host_regs_test;
  localparam [1:0] OK = `FHC_RESP_OKAY;
  localparam [1:0] ER = `FHC_RESP_SLVERR;
  logic        clk = 0, sys_rst = 1, master_reset_input = 0;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0, write_shift_sel;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1, core_seeking, tape_drive_en;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_data_ready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, drive_sel, data_rate, tape_select;
  logic        core_to_host, core_exec_phase, core_non_dma, core_cmd_busy;
  logic        core_dma_req, core_irq, motor_a_en, dma_req_out, irq_out;
  logic        core_reset, power_down, reduced_write_current;
  logic [10:0] stim = 0;
  logic [10:0] pat [4] = '{11'h1ff, 11'h0a5, 11'h15a, 11'h1e0};
  int          num_errors = 0, n_checks = 0, k;

  fhc_host_regs #(.SWRST_CYCLES(8'd2)) DUT (.*);
  fhc_core_model u_core (.*);

  always #2 clk = ~clk;

  task chk(input [31:0] got, input [31:0] exp, input string nm);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic step(ref int n);
    @(posedge clk);
    n++;
    if (n >= 40)
    begin
      num_errors++;
      wrap_up;
    end
  endtask

  task tick(input int c);
    repeat (c) @(negedge clk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input [5:0] a, input [7:0] d, input [1:0] er);
    int n = 0;
    bit ga = 0;
    bit gw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ga && gw))
    begin
      step(n);
      ga = ga | s_axi_awready;
      gw = gw | s_axi_wready;
      if (ga) s_axi_awvalid <= 0;
      if (gw) s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid) step(n);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er, "bresp");
  endtask

  // rready held back one edge so the data must stand
  task automatic rd(input [5:0] a, input [31:0] ed, input [1:0] er);
    int n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do step(n); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    step(n);
    s_axi_rready <= 1;
    do step(n); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(s_axi_rdata, ed, "rdata");
    chk(s_axi_rresp, er, "rresp");
  endtask

  function automatic [31:0] ms(input [10:0] p);
    return {24'h0, p[8], p[7], p[6] & p[5], p[4], p[3:0]};
  endfunction

  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    tick(1);
    chk({motor_a_en, drive_sel, core_reset, power_down, write_shift_sel, data_rate,
      reduced_write_current, tape_select}, 13'h0210, "reset");
    for (int s = 0; s < 4; s++)
    begin
      wr(6'h08, {6'h3d, s[1:0]}, OK);
      tick(2);
      chk({motor_a_en, core_reset, drive_sel}, {2'h2, s[1:0]}, "drive out");
    end
    rd(6'h08, 0, OK);
    wr(6'h08, 8'h0c, OK);
    stim <= 11'h600;
    tick(3);
    chk({motor_a_en, dma_req_out, irq_out}, 3'h3, "gate on");
    wr(6'h08, 8'h04, OK);
    tick(2);
    chk({dma_req_out, irq_out}, 2'h0, "gate off");
    foreach (pat[i])
    begin
      stim <= pat[i];
      rd(6'h10, ms(pat[i]), OK);
    end
    for (int t = 0; t < 4; t++)
    begin
      wr(6'h0c, {6'h3f, t[1:0]}, OK);
      rd(6'h0c, t, OK);
      chk({tape_select, tape_drive_en}, {t[1:0], t ? 4'h1 << t : 4'h0}, "tape");
    end
    // lane 0 strobe low: write answered but ignored
    s_axi_wstrb <= 4'h0;
    wr(6'h0c, 8'h01, OK);
    s_axi_wstrb <= 4'h1;
    rd(6'h0c, 32'h03, OK);
    // three-mode view: drive 2 then drive 3 selected
    wr(6'h20, 8'h01, OK);
    rd(6'h20, 32'h01, OK);
    wr(6'h24, 8'hb0, OK);
    wr(6'h28, 8'hd8, OK);
    wr(6'h08, 8'h06, OK);
    rd(6'h0c, 32'hdb, OK);
    wr(6'h08, 8'h07, OK);
    rd(6'h0c, 32'hfb, OK);
    for (int c = 0; c < 4; c++)
    begin
      wr(6'h10, {1'b0, c[0], 1'b0, 3'(c + 3), c[1:0]}, OK);
      tick(2);
      chk({power_down, write_shift_sel, data_rate, reduced_write_current},
        {c[0], 3'(c + 3), c[1:0], c == 0 || c == 3}, "rate");
    end
    wr(6'h1c, 8'h01, OK);
    tick(2);
    chk(data_rate, 2'h1, "config last");
    wr(6'h10, 8'h00, OK);
    tick(2);
    chk(data_rate, 2'h0, "rate last");
    wr(6'h20, 8'h03, OK);
    tick(2);
    chk(data_rate, 2'h1, "compat");
    rd(6'h1c, 0, ER);
    wr(6'h3c, 8'hff, ER);
    rd(6'h3c, 0, ER);
    wr(6'h10, 8'h82, OK);
    for (k = 0; k < 8 && !core_reset; k++) tick(1);
    chk(core_reset, 1'b1, "swrst on");
    for (k = 0; k < 8 && core_reset; k++) tick(1);
    chk(core_reset, 1'b0, "swrst off");
    chk(k, 2, "swrst len");
    wr(6'h20, 8'h00, OK);
    wr(6'h08, 8'h1f, OK);
    wr(6'h10, 8'h5d, OK);
    @(posedge clk);
    master_reset_input <= 1;
    tick(8);
    chk({motor_a_en, drive_sel, core_reset, power_down, write_shift_sel, data_rate},
      10'h042, "master reset");
    @(posedge clk);
    master_reset_input <= 0;
    tick(4);
    wrap_up;
  end
endmodule // fhc_host_regs_test
